// ---- core/pll_ovr_regs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef PLL_OVR_REGS_SVH
`define PLL_OVR_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_PLL_OVERRIDE_CONTROL 8'h58
`define ADDR_OSCILLATOR_TRIM_VALUE 8'h59
`define ADDR_PLL_PROGRAM_RESET_CTRL 8'h5C

// ****************************************************************
// Field positions
// ****************************************************************
`define OVR_EN_BIT 7
`define OVR_D_SEL_MSB 5
`define OVR_D_SEL_LSB 4
`define OVR_C_SEL_MSB 3
`define OVR_C_SEL_LSB 2
`define OVR_SE_BIT 1
`define OVR_PLL_EN_BIT 0
`define TRIM_MSB 6
`define PROG_RESET_BIT 0

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_PLL_OVERRIDE_CONTROL 8'h00
`define RST_OSCILLATOR_TRIM_VALUE 8'h00
`define RST_PLL_PROGRAM_RESET_CTRL 8'h00
`define RST_TRIM_TRIAL 7'h40

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_SYS_MHZ 20
`define OSC_CAL_SETTLE_NS 1000
`define OSC_CAL_SETTLE_CYCLES \
  ((`OSC_CAL_SETTLE_NS * `CLK_SYS_MHZ + 999) / 1000)

`endif

// ---- core/pll_ovr_pkg.sv ----
// Types shared by the override register block and calibration engine
package pll_ovr_pkg;

  // ****************************************************************
  // Calibration engine states, one-hot
  // ****************************************************************
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN = 2'b10
  } cal_state_type;

  // Whole state of the calibration engine
  typedef struct packed {
    cal_state_type state;
    logic [6:0] trim;
    logic [2:0] bit_idx;
    logic [7:0] cnt;
    logic done;
    logic we;
  } cal_regs_type;

  // Whole state of the override register block
  typedef struct packed {
    logic [7:0] ovr;
    logic [7:0] trim;
    logic [7:0] prst;
    logic [7:0] rdata;
    logic rvalid;
    logic pll_en;
    logic se_sel;
    logic [1:0] c_sel;
    logic [1:0] d_sel;
  } ovr_regs_type;

endpackage

// ---- core/osc_cal_engine.sv ----
// Successive-approximation oscillator trim calibration engine
`timescale 1ns/1ns
`include "pll_ovr_regs.svh"

module osc_cal_engine #(
  parameter int SETTLE_CYCLES = `OSC_CAL_SETTLE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire logic i_enable,
  input wire logic i_prog_reset,
  input wire logic i_too_fast,
  output logic [6:0] o_trim,
  output logic o_trim_we,
  output logic o_done,
  output logic o_busy
);

  pll_ovr_pkg::cal_regs_type st_r;
  pll_ovr_pkg::cal_regs_type st_nxt;
  logic [2:0] next_idx;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // One trim bit per step, MSB first, each after a settle wait
  always_comb begin
    st_nxt = st_r;
    st_nxt.we = 1'b0;
    next_idx = st_r.bit_idx - 3'h1;
    case (st_r.state)
      pll_ovr_pkg::CAL_IDLE: begin
        if (i_start && !i_enable) begin
          st_nxt.done = 1'b1;
        end else if (i_start) begin
          st_nxt.state = pll_ovr_pkg::CAL_RUN;
          st_nxt.trim = `RST_TRIM_TRIAL;
          st_nxt.bit_idx = 3'h6;
          st_nxt.cnt = 8'(SETTLE_CYCLES);
          st_nxt.we = 1'b1;
          st_nxt.done = 1'b0;
        end
      end
      pll_ovr_pkg::CAL_RUN: begin
        if (st_r.cnt != 8'h00) begin
          st_nxt.cnt = st_r.cnt - 8'h01;
        end else begin
          // Oscillator above target: drop the trial bit
          if (i_too_fast) begin
            st_nxt.trim[st_r.bit_idx] = 1'b0;
          end
          st_nxt.we = 1'b1;
          if (st_r.bit_idx == 3'h0) begin
            st_nxt.state = pll_ovr_pkg::CAL_IDLE;
            st_nxt.done = 1'b1;
          end else begin
            st_nxt.trim[next_idx] = 1'b1;
            st_nxt.bit_idx = next_idx;
            st_nxt.cnt = 8'(SETTLE_CYCLES);
          end
        end
      end
      default: begin
        st_nxt.state = pll_ovr_pkg::CAL_IDLE;
      end
    endcase
    // Holding program reset aborts and clears done, start excepted
    if (i_prog_reset && !i_start) begin
      st_nxt.state = pll_ovr_pkg::CAL_IDLE;
      st_nxt.done = 1'b0;
      st_nxt.we = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_r <= '{state: pll_ovr_pkg::CAL_IDLE, trim: 7'h00,
                bit_idx: 3'h0, cnt: 8'h00, done: 1'b0, we: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Trim, write and done straight from the state flops; busy decoded from state
  assign o_trim = st_r.trim;
  assign o_trim_we = st_r.we;
  assign o_done = st_r.done;
  assign o_busy = (st_r.state == pll_ovr_pkg::CAL_RUN);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_CAL_SKIP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_start && !i_enable && !o_busy) |=> o_done && !o_busy)
    else $error("skipped calibration did not report done");
  AST_CAL_START: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_start && i_enable && !o_busy) |=> o_busy && !o_done ##0
    o_trim == 7'h40)
    else $error("calibration did not start with mid trim");
  AST_TRIM_WE_CAL: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_trim_we |-> o_busy || $past(o_busy) || o_done)
    else $error("trim written outside calibration");
  AST_PROG_RESET_CLEARS: assert property (@(posedge i_clk)
    disable iff (!i_rst_b)
    (i_prog_reset && !i_start) |=> !o_done && !o_busy)
    else $error("done or busy while program reset held");
  COV_CAL_DONE: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    o_busy ##1 !o_busy && o_done);

endmodule

// ---- core/pll_pin_override_and_trim.sv ----
// Pin or register control of the sampling PLL, and oscillator trim
`timescale 1ns/1ns
`include "pll_ovr_regs.svh"

// Function
// - Override bit 7 low: PLL controls come from the pins.
// - Override bit 7 high: PLL controls come from the register fields.
// - Register mode, bits 5:4 pick output D: off, divide 1, 2, 4.
// - Pin mode, output D function follows the two configuration pins.
// - Output D never runs unless output C runs.
// - Register mode, bits 3:2 pick output C: off, divide 1, 2, 4.
// - Pin mode, output C function follows the two configuration pins.
// - Register mode, bit 1 selects the single-ended reference input.
// - Register mode, bit 0 enables the sampling PLL.
// - Seven-bit trim sets oscillator; calibration loads it; readable.
// - A trim value written by software is applied to the oscillator unless calibration is running or writing its last step.
// - Reset clears the override register: pin mode, outputs off.
// - Writing program reset from one to zero starts calibration when enabled.
// - Calibration done reads one when finished or skipped.
module pll_pin_override_and_trim #(
  parameter int SETTLE_CYCLES = `OSC_CAL_SETTLE_CYCLES
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire logic i_REG_WR,
  input wire logic i_REG_RD,
  input wire logic [7:0] i_REG_ADDR,
  input wire logic [7:0] i_REG_WDATA,
  input wire logic i_PLL_ENABLE_PIN,
  input wire logic i_SINGLE_ENDED_REF_PIN,
  input wire logic i_CLOCK_CONFIG_PIN_0,
  input wire logic i_CLOCK_CONFIG_PIN_1,
  input wire logic i_OSC_CAL_ENABLE,
  input wire logic i_OSC_TOO_FAST,
  output logic [7:0] o_REG_RDATA,
  output logic o_REG_RVALID,
  output logic o_PLL_ENABLE,
  output logic o_SINGLE_ENDED_REF_SELECT,
  output logic [1:0] o_REF_OUTPUT_C_SEL,
  output logic [1:0] o_REF_OUTPUT_D_SEL,
  output logic [6:0] o_OSCILLATOR_TRIM,
  output logic o_PLL_PROGRAM_RESET,
  output logic o_OSC_CAL_DONE,
  output logic o_OSC_CAL_BUSY
);

  pll_ovr_pkg::ovr_regs_type st_r;
  pll_ovr_pkg::ovr_regs_type st_nxt;
  logic wr_ovr;
  logic wr_trim;
  logic wr_prst;
  logic cal_start;
  logic [6:0] cal_trim;
  logic cal_trim_we;
  logic cal_done;
  logic cal_busy;
  logic [1:0] c_mode;
  logic [1:0] d_mode;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  assign wr_ovr = i_REG_WR && (i_REG_ADDR == `ADDR_PLL_OVERRIDE_CONTROL);
  assign wr_trim = i_REG_WR && (i_REG_ADDR == `ADDR_OSCILLATOR_TRIM_VALUE);
  assign wr_prst = i_REG_WR &&
                   (i_REG_ADDR == `ADDR_PLL_PROGRAM_RESET_CTRL);
  // Only a falling write of program reset starts calibration
  assign cal_start = wr_prst && !i_REG_WDATA[`PROG_RESET_BIT] &&
                     st_r.prst[`PROG_RESET_BIT];

  // ****************************************************************
  // Calibration engine
  // ****************************************************************
  osc_cal_engine #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_cal (
    .i_clk(I_CLK_SYS),
    .i_rst_b(I_RST_B),
    .i_start(cal_start),
    .i_enable(i_OSC_CAL_ENABLE),
    .i_prog_reset(st_r.prst[`PROG_RESET_BIT]),
    .i_too_fast(i_OSC_TOO_FAST),
    .o_trim(cal_trim),
    .o_trim_we(cal_trim_we),
    .o_done(cal_done),
    .o_busy(cal_busy)
  );

  // ****************************************************************
  // Control source selection
  // ****************************************************************
  // Pins give one code to both outputs; register fields give each output its own
  always_comb begin
    if (st_r.ovr[`OVR_EN_BIT]) begin
      c_mode = st_r.ovr[`OVR_C_SEL_MSB:`OVR_C_SEL_LSB];
      d_mode = st_r.ovr[`OVR_D_SEL_MSB:`OVR_D_SEL_LSB];
    end else begin
      c_mode = {i_CLOCK_CONFIG_PIN_1, i_CLOCK_CONFIG_PIN_0};
      d_mode = {i_CLOCK_CONFIG_PIN_1, i_CLOCK_CONFIG_PIN_0};
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = i_REG_RD;
    if (wr_ovr) begin
      st_nxt.ovr = i_REG_WDATA;
    end
    if (wr_prst) begin
      st_nxt.prst = i_REG_WDATA;
    end
    // Engine owns the trim while it runs; software writes lose then
    if (cal_trim_we) begin
      st_nxt.trim[`TRIM_MSB:0] = cal_trim;
    end else if (wr_trim && !cal_busy) begin
      st_nxt.trim = i_REG_WDATA;
    end
    // Read answer one cycle after the strobe; unmapped reads zero
    case (i_REG_ADDR)
      `ADDR_PLL_OVERRIDE_CONTROL: st_nxt.rdata = st_r.ovr;
      `ADDR_OSCILLATOR_TRIM_VALUE: st_nxt.rdata = st_r.trim;
      `ADDR_PLL_PROGRAM_RESET_CTRL: st_nxt.rdata = st_r.prst;
      default: st_nxt.rdata = 8'h00;
    endcase
    if (!i_REG_RD) begin
      st_nxt.rdata = 8'h00;
    end
    // PLL enable and reference select
    if (st_r.ovr[`OVR_EN_BIT]) begin
      st_nxt.pll_en = st_r.ovr[`OVR_PLL_EN_BIT];
      st_nxt.se_sel = st_r.ovr[`OVR_SE_BIT];
    end else begin
      st_nxt.pll_en = i_PLL_ENABLE_PIN;
      st_nxt.se_sel = i_SINGLE_ENDED_REF_PIN;
    end
    st_nxt.c_sel = c_mode;
    // Output D is gated by output C running
    st_nxt.d_sel = (c_mode == 2'h0) ? 2'h0 : d_mode;
  end

  // State register
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      st_r <= '{ovr: `RST_PLL_OVERRIDE_CONTROL,
                trim: `RST_OSCILLATOR_TRIM_VALUE,
                prst: `RST_PLL_PROGRAM_RESET_CTRL,
                rdata: 8'h00, rvalid: 1'b0, pll_en: 1'b0,
                se_sel: 1'b0, c_sel: 2'h0, d_sel: 2'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs from flops, except calibration busy, decoded from engine state
  // ****************************************************************
  assign o_REG_RDATA = st_r.rdata;
  assign o_REG_RVALID = st_r.rvalid;
  assign o_PLL_ENABLE = st_r.pll_en;
  assign o_SINGLE_ENDED_REF_SELECT = st_r.se_sel;
  assign o_REF_OUTPUT_C_SEL = st_r.c_sel;
  assign o_REF_OUTPUT_D_SEL = st_r.d_sel;
  assign o_OSCILLATOR_TRIM = st_r.trim[`TRIM_MSB:0];
  assign o_PLL_PROGRAM_RESET = st_r.prst[`PROG_RESET_BIT];
  assign o_OSC_CAL_DONE = cal_done;
  assign o_OSC_CAL_BUSY = cal_busy;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_PIN_PLL_EN: assert property (@(posedge I_CLK_SYS)
    disable iff (!I_RST_B) !st_r.ovr[7] |=>
    o_PLL_ENABLE == $past(i_PLL_ENABLE_PIN) &&
    o_SINGLE_ENDED_REF_SELECT == $past(i_SINGLE_ENDED_REF_PIN))
    else $error("pin mode not taken from pins");
  AST_REG_PLL_EN: assert property (@(posedge I_CLK_SYS)
    disable iff (!I_RST_B) st_r.ovr[7] |=>
    o_PLL_ENABLE == $past(st_r.ovr[0]))
    else $error("register mode PLL enable wrong");
  AST_REG_SE: assert property (@(posedge I_CLK_SYS)
    disable iff (!I_RST_B) st_r.ovr[7] |=>
    o_SINGLE_ENDED_REF_SELECT == $past(st_r.ovr[1]))
    else $error("register mode reference select wrong");
  AST_REG_C: assert property (@(posedge I_CLK_SYS)
    disable iff (!I_RST_B) (st_r.ovr[7] && wr_ovr == 1'b0) |=>
    o_REF_OUTPUT_C_SEL == $past(st_r.ovr[3:2]))
    else $error("register mode output C wrong");
  AST_REG_D: assert property (@(posedge I_CLK_SYS)
    disable iff (!I_RST_B)
    (st_r.ovr[7] && st_r.ovr[3:2] != 2'h0) |=>
    o_REF_OUTPUT_D_SEL == $past(st_r.ovr[5:4]))
    else $error("register mode output D wrong");
  AST_PIN_C: assert property (@(posedge I_CLK_SYS)
    disable iff (!I_RST_B) !st_r.ovr[7] |=>
    o_REF_OUTPUT_C_SEL ==
    $past({i_CLOCK_CONFIG_PIN_1, i_CLOCK_CONFIG_PIN_0}))
    else $error("pin mode output C wrong");
  AST_PIN_D: assert property (@(posedge I_CLK_SYS)
    disable iff (!I_RST_B) !st_r.ovr[7] |=>
    o_REF_OUTPUT_D_SEL == o_REF_OUTPUT_C_SEL)
    else $error("pin mode output D wrong");
  AST_D_NEEDS_C: assert property (@(posedge I_CLK_SYS)
    disable iff (!I_RST_B) o_REF_OUTPUT_C_SEL == 2'h0 |->
    o_REF_OUTPUT_D_SEL == 2'h0)
    else $error("output D running without output C");
  AST_RESET_CLEARS: assert property (@(posedge I_CLK_SYS)
    !I_RST_B |=> st_r.ovr == 8'h00 && st_r.prst == 8'h00)
    else $error("reset did not clear override");
  AST_TRIM_WRITE: assert property (@(posedge I_CLK_SYS)
    disable iff (!I_RST_B) (wr_trim && !cal_busy && !cal_trim_we) |=>
    o_OSCILLATOR_TRIM == $past(i_REG_WDATA[6:0]))
    else $error("software trim not applied");
  AST_TRIM_READ: assert property (@(posedge I_CLK_SYS)
    disable iff (!I_RST_B)
    (i_REG_RD && i_REG_ADDR == 8'h59) |=>
    o_REG_RVALID && o_REG_RDATA[6:0] == $past(o_OSCILLATOR_TRIM))
    else $error("trim readback wrong");
  AST_CAL_KICK: assert property (@(posedge I_CLK_SYS)
    disable iff (!I_RST_B) (cal_start && i_OSC_CAL_ENABLE && !cal_busy)
    |=> cal_busy ##[1:300] cal_done)
    else $error("calibration did not complete in time");
  COV_REG_MODE_D: cover property (@(posedge I_CLK_SYS)
    disable iff (!I_RST_B) st_r.ovr[7] && o_REF_OUTPUT_D_SEL == 2'h3);
  COV_PIN_MODE_C: cover property (@(posedge I_CLK_SYS)
    disable iff (!I_RST_B) !st_r.ovr[7] && o_REF_OUTPUT_C_SEL == 2'h2);
  COV_CAL_SKIP: cover property (@(posedge I_CLK_SYS)
    disable iff (!I_RST_B) cal_start && !i_OSC_CAL_ENABLE ##1 cal_done);

endmodule

// ---- sim/osc_comparator_model.sv ----
// Behavioural oscillator comparator standing behind the trim output
`timescale 1ns/1ns

// ****************************************************************
// Oscillator comparator model
// ****************************************************************
module osc_comparator_model #(
  parameter logic [6:0] TARGET = 7'h2B
) (
  input wire logic [6:0] i_trim,
  output logic o_too_fast
);
  // Ideal settling, so the result depends only on the applied trim
  assign o_too_fast = (i_trim > TARGET);
endmodule

// ---- sim/tb_pll_pin_override_and_trim.sv ----
// Self-checking testbench for the PLL override and trim block
`timescale 1ns/1ns
`include "pll_ovr_regs.svh"

module tb_pll_pin_override_and_trim;
  // Even target, so the last step clears bit 0 as done is reported
  localparam logic [6:0] TARGET = 7'h2A;
  logic clk, rst_b, wr, rd, pin_en, pin_se, cfg0, cfg1, cal_en, too_fast;
  logic [7:0] addr, wdata, rdata;
  logic rvalid, pll_en, se_sel, prst, done, busy;
  logic [1:0] c_sel, d_sel, ed;
  logic [6:0] trim;
  int err_total = 0;
  int checks = 0;

  // ****************************************************************
  // Design, comparator model and clock
  // ****************************************************************
  pll_pin_override_and_trim #(.SETTLE_CYCLES(2)) DUT (
    .I_CLK_SYS(clk), .I_RST_B(rst_b), .i_REG_WR(wr), .i_REG_RD(rd),
    .i_REG_ADDR(addr), .i_REG_WDATA(wdata), .i_PLL_ENABLE_PIN(pin_en),
    .i_SINGLE_ENDED_REF_PIN(pin_se), .i_CLOCK_CONFIG_PIN_0(cfg0),
    .i_CLOCK_CONFIG_PIN_1(cfg1), .i_OSC_CAL_ENABLE(cal_en),
    .i_OSC_TOO_FAST(too_fast), .o_REG_RDATA(rdata),
    .o_REG_RVALID(rvalid), .o_PLL_ENABLE(pll_en),
    .o_SINGLE_ENDED_REF_SELECT(se_sel), .o_REF_OUTPUT_C_SEL(c_sel),
    .o_REF_OUTPUT_D_SEL(d_sel), .o_OSCILLATOR_TRIM(trim),
    .o_PLL_PROGRAM_RESET(prst), .o_OSC_CAL_DONE(done),
    .o_OSC_CAL_BUSY(busy)
  );

  osc_comparator_model #(.TARGET(TARGET)) u_osc (
    .i_trim(trim), .o_too_fast(too_fast)
  );

  // Free-running 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // Access and compare tasks
  // ****************************************************************
  task automatic final_report();
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One-cycle write strobe, taken at the edge that lowers it
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read answer stands for one cycle, so it is sampled in that cycle
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read_valid", 8'h01, {7'h00, rvalid});
    chk("read_data", exp, rdata);
  endtask

  // Allow the one-cycle path from register or pin to the outputs
  task automatic out_chk(input logic en, input logic se,
                         input logic [1:0] c, input logic [1:0] d);
    repeat (3) @(posedge clk);
    #1;
    chk("pll_outputs", {2'h0, en, se, c, d},
        {2'h0, pll_en, se_sel, c_sel, d_sel});
  endtask

  // Bounded wait for calibration to report done
  task automatic wait_done();
    int n;
    n = 0;
    // Look after the edge settles, never in the launching time step
    #1;
    while (done !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 400) begin
      err_total++;
      $display("[ERR] cal_done expected 1 seen %b", done);
      final_report();
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rst_b, wr, rd, pin_en, pin_se, cfg0, cfg1, cal_en} = 8'h00;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    // Reset state of registers and outputs
    reg_rd(`ADDR_PLL_OVERRIDE_CONTROL, 8'h00);
    reg_rd(`ADDR_OSCILLATOR_TRIM_VALUE, 8'h00);
    reg_rd(`ADDR_PLL_PROGRAM_RESET_CTRL, 8'h00);
    out_chk(1'b0, 1'b0, 2'h0, 2'h0);
    // Register fields loaded but pin mode kept: they must be ignored
    reg_wr(`ADDR_PLL_OVERRIDE_CONTROL, 8'h3F);
    for (int p = 0; p < 16; p++) begin
      @(posedge clk);
      {pin_en, pin_se, cfg1, cfg0} <= 4'(p);
      out_chk(p[3], p[2], 2'(p), 2'(p));
    end
    // Register mode with every code pair, enable and config pins set the other way
    for (int v = 0; v < 16; v++) begin
      @(posedge clk);
      pin_en <= ~v[0];
      pin_se <= ~v[2];
      {cfg1, cfg0} <= ~v[3:2];
      reg_wr(`ADDR_PLL_OVERRIDE_CONTROL, {2'b10, 6'(v)});
      out_chk(v[0], v[1], v[3:2], 2'h0);
      reg_wr(`ADDR_PLL_OVERRIDE_CONTROL, {2'b10, 2'(v), 2'(v >> 2), 2'(v)});
      // Field D holds v[1:0], field C holds v[3:2]; D gated by C
      ed = (v[3:2] == 2'h0) ? 2'h0 : v[1:0];
      out_chk(v[0], v[1], v[3:2], ed);
      reg_rd(`ADDR_PLL_OVERRIDE_CONTROL,
             {2'b10, 2'(v), 2'(v >> 2), 2'(v)});
    end
    // Unmapped place reads zero and ignores writes
    reg_wr(8'h5A, 8'h7F);
    reg_rd(8'h5A, 8'h00);
    // Software-restored trim is readable and applied
    reg_wr(`ADDR_OSCILLATOR_TRIM_VALUE, 8'h35);
    reg_rd(`ADDR_OSCILLATOR_TRIM_VALUE, 8'h35);
    chk("trim_out", 8'h35, {1'b0, trim});
    // Calibration skipped when disabled: done without touching trim
    reg_wr(`ADDR_PLL_PROGRAM_RESET_CTRL, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk("prog_reset", 8'h01, {7'h00, prst});
    reg_wr(`ADDR_PLL_PROGRAM_RESET_CTRL, 8'h00);
    wait_done();
    chk("trim_skip", 8'h35, {1'b0, trim});
    // Full run: no trim access until done is reported
    reg_wr(`ADDR_PLL_PROGRAM_RESET_CTRL, 8'h01);
    cal_en <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("done_clear", 8'h00, {7'h00, done});
    reg_wr(`ADDR_PLL_PROGRAM_RESET_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk("cal_busy", 8'h01, {7'h00, busy});
    wait_done();
    chk("cal_idle", 8'h00, {7'h00, busy});
    // Trim register takes the engine's last step one cycle after done
    @(posedge clk);
    #1;
    chk("trim_cal", {1'b0, TARGET}, {1'b0, trim});
    reg_rd(`ADDR_OSCILLATOR_TRIM_VALUE, {1'b0, TARGET});
    final_report();
  end
endmodule
